//--- switch_port_policy_pkg.sv
/*
  Shared types and constants for the switch port policy block: per-port
  configuration encodings, frame descriptor layout and timing figures.
  Assumes a 200 MHz system clock.
*/
package switch_port_policy_pkg;

  localparam int EXT_PORTS = 4;
  localparam int ALL_PORTS = 5;
  localparam int INT_PORT = 4;

  typedef enum logic [1:0] {SPEED_AUTO, SPEED_10, SPEED_100, SPEED_1000} speed_type;
  typedef enum logic [1:0] {DUPLEX_AUTO, DUPLEX_FULL, DUPLEX_HALF} duplex_type;
  typedef enum logic [1:0] {LIMIT_OFF, LIMIT_BCAST, LIMIT_MCAST_BCAST} limit_type;
  typedef enum logic [1:0] {LLDP_OFF, LLDP_SEND, LLDP_RECV, LLDP_BOTH} lldp_type;
  typedef enum logic [2:0] {MIR_OFF, MIR_EGRESS, MIR_INGRESS, MIR_BOTH, MIR_DEST} mirror_type;
  typedef enum logic [1:0] {KIND_UNICAST, KIND_MCAST, KIND_BCAST, KIND_LLDP} kind_type;

  typedef struct packed {
    speed_type speed;
    duplex_type duplex;
    logic adv_fixed;
    limit_type limit;
    lldp_type lldp;
    mirror_type mirror;
  } port_cfg_type;

  typedef struct packed {
    logic autoneg;
    logic advertise;
    speed_type speed;
    duplex_type duplex;
  } phy_ctl_type;

  typedef struct packed {
    logic [2:0] src;
    kind_type kind;
    logic [15:0] len;
    logic [4:0] dest;
  } desc_type;

  typedef struct packed {
    logic [2:0] src;
    logic [15:0] len;
    logic [4:0] egress;
    logic dropped;
  } decision_type;

  localparam port_cfg_type CFG_RESET = '{speed: SPEED_AUTO, duplex: DUPLEX_AUTO, adv_fixed: 1'b0,
                                         limit: LIMIT_BCAST, lldp: LLDP_BOTH, mirror: MIR_OFF};
  localparam logic [4:0] VLAN_ROW_RESET = 5'h1f;

  localparam int CLK_MHZ = 200;
  localparam int BCAST_KBPS = 128;
  localparam int MCBC_KBPS = 1024;
  localparam int REFILL_US = 1000;
  localparam int REFILL_CYCLES = REFILL_US * CLK_MHZ;
  localparam logic [15:0] BCAST_BYTES = 16'(BCAST_KBPS * REFILL_US / 8000);
  localparam logic [15:0] MCBC_BYTES = 16'(MCBC_KBPS * REFILL_US / 8000);
  localparam logic [15:0] CREDIT_CAP = 16'h0600;
  localparam int LLDP_PERIOD_S = 30;
  localparam longint LLDP_PERIOD_CYCLES = longint'(LLDP_PERIOD_S) * CLK_MHZ * 1000000;
  localparam int FIFO_DEPTH = 16;

endpackage : switch_port_policy_pkg

//--- switch_port_policy.sv
/*
  Port policy engine of a four-port switch with one internal port: per-port
  PHY settings, inbound rate limiting, port-based forwarding, LLDP gating,
  mirroring. Frame descriptors pass a FIFO, then a one-cycle decision stage.
  Assumes a lookup upstream supplies the destination mask of each frame.
*/
// Contract
// - Four external ports, one configuration each
// - Speed fixed 10/100/1000 or auto; auto default
// - Duplex full, half or auto; auto default
// - Advertise abilities even with fixed settings
// - Limiter off or broadcast 128 kbit/s; default
// - Combined limit multicast+broadcast at 1024 kbit/s
// - Forward only to enabled ports per ingress
// - All forwarding connections enabled after reset
// - Periodically send LLDP, accept neighbour LLDP
// - LLDP mode set per external port
// - LLDP off: no send, no processing
// - Send-only: transmit, discard received LLDP
// - Receive-only: no transmit, process received
// - Send/receive both; default LLDP mode
// - Mirror off: no copies; default role
// - Egress role copies transmitted frames
// - Ingress role copies received frames
// - Combined role copies both directions
// - Destination role port transmits mirror copies

////////////////////////////////////////////////////////////////////////////////
module policy_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("policy_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;

  assign o_in_ready = cnt_q != (AW+1)'(DEPTH);
  assign o_out_valid = cnt_q != '0;
  assign o_out_data = mem_q[rd_q];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_q + AW'(push);
      rd_q <= rd_q + AW'(pop);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  chk_fifo_bound: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule : policy_fifo

////////////////////////////////////////////////////////////////////////////////
module switch_port_policy #(
  parameter int REFILL_CYCLES = switch_port_policy_pkg::REFILL_CYCLES,
  parameter longint LLDP_PERIOD_CYCLES = switch_port_policy_pkg::LLDP_PERIOD_CYCLES,
  parameter int FIFO_DEPTH = switch_port_policy_pkg::FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_cfg_wr,
  input wire logic [1:0] i_cfg_port,
  input wire switch_port_policy_pkg::port_cfg_type i_cfg,
  input wire logic i_vlan_wr,
  input wire logic [2:0] i_vlan_port,
  input wire logic [4:0] i_vlan_row,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire switch_port_policy_pkg::desc_type i_in_desc,
  output logic o_dec_valid,
  input wire logic i_dec_ready,
  output switch_port_policy_pkg::decision_type o_dec,
  output switch_port_policy_pkg::port_cfg_type o_port_cfg [4],
  output switch_port_policy_pkg::phy_ctl_type o_phy_ctl [4],
  output logic [3:0] o_lldp_tx_req
);
  if (REFILL_CYCLES < 2 || LLDP_PERIOD_CYCLES < 2 ||
      LLDP_PERIOD_CYCLES > 64'h0000_0003_ffff_ffff) begin : g_bad_period
    $error("period counts out of range");
  end

  function automatic logic sends(switch_port_policy_pkg::lldp_type m);
    return m == switch_port_policy_pkg::LLDP_SEND || m == switch_port_policy_pkg::LLDP_BOTH;
  endfunction : sends

  function automatic logic receives(switch_port_policy_pkg::lldp_type m);
    return m == switch_port_policy_pkg::LLDP_RECV || m == switch_port_policy_pkg::LLDP_BOTH;
  endfunction : receives

  //////////////////////////////////////////////////////////////////////////////
  // Configuration store: a write replaces the whole set of one port.
  switch_port_policy_pkg::port_cfg_type cfg_q [4];
  logic [4:0] vlan_q [5];
  switch_port_policy_pkg::phy_ctl_type phy_q [4];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        cfg_q[i] <= switch_port_policy_pkg::CFG_RESET;
      end
      for (int i = 0; i < 5; i++) begin
        vlan_q[i] <= switch_port_policy_pkg::VLAN_ROW_RESET;
      end
    end else begin
      if (i_cfg_wr) begin
        cfg_q[i_cfg_port] <= i_cfg;
      end
      if (i_vlan_wr && i_vlan_port <= 3'(switch_port_policy_pkg::INT_PORT)) begin
        vlan_q[i_vlan_port] <= i_vlan_row;
      end
    end
  end

  // Fixed settings still advertise when asked, so negotiating partners see them.
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < 4; i++) begin
      phy_q[i].autoneg <= !i_sys_rst ? (cfg_q[i].speed == switch_port_policy_pkg::SPEED_AUTO ||
                          cfg_q[i].duplex == switch_port_policy_pkg::DUPLEX_AUTO) : 1'b1;
      phy_q[i].advertise <= i_sys_rst || cfg_q[i].adv_fixed ||
                            cfg_q[i].speed == switch_port_policy_pkg::SPEED_AUTO ||
                            cfg_q[i].duplex == switch_port_policy_pkg::DUPLEX_AUTO;
      phy_q[i].speed <= i_sys_rst ? switch_port_policy_pkg::SPEED_AUTO : cfg_q[i].speed;
      phy_q[i].duplex <= i_sys_rst ? switch_port_policy_pkg::DUPLEX_AUTO : cfg_q[i].duplex;
    end
  end

  assign o_port_cfg = cfg_q;
  assign o_phy_ctl = phy_q;

  //////////////////////////////////////////////////////////////////////////////
  // Periodic ticks: limiter refill and LLDP announcement.
  logic [31:0] refill_cnt_q;
  // A thirty second announcement period at this clock does not fit in 32 bits.
  logic [33:0] lldp_cnt_q;
  logic [3:0] lldp_req_q;
  wire refill_tick = refill_cnt_q == 32'(REFILL_CYCLES - 1);
  wire lldp_tick = lldp_cnt_q == 34'(LLDP_PERIOD_CYCLES - 1);
  logic [3:0] send_mask;
  logic [3:0] egmir_mask;
  logic [3:0] dest_mask;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      send_mask[i] = sends(cfg_q[i].lldp);
      egmir_mask[i] = cfg_q[i].mirror == switch_port_policy_pkg::MIR_EGRESS ||
                      cfg_q[i].mirror == switch_port_policy_pkg::MIR_BOTH;
      dest_mask[i] = cfg_q[i].mirror == switch_port_policy_pkg::MIR_DEST;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      refill_cnt_q <= '0;
      lldp_cnt_q <= '0;
      lldp_req_q <= '0;
    end else begin
      refill_cnt_q <= refill_tick ? '0 : refill_cnt_q + 32'h1;
      lldp_cnt_q <= lldp_tick ? '0 : lldp_cnt_q + 34'h1;
      lldp_req_q <= lldp_tick ? send_mask : 4'h0;
    end
  end

  assign o_lldp_tx_req = lldp_req_q;

  //////////////////////////////////////////////////////////////////////////////
  // Descriptor FIFO; the decision register drains it and can stall it.
  switch_port_policy_pkg::desc_type head;
  logic head_valid;
  logic take;

  policy_fifo #(
    .WIDTH($bits(switch_port_policy_pkg::desc_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(i_in_valid),
    .o_in_ready(o_in_ready),
    .i_in_data(i_in_desc),
    .o_out_valid(head_valid),
    .i_out_ready(!o_dec_valid || i_dec_ready),
    .o_out_data(head)
  );

  assign take = head_valid && (!o_dec_valid || i_dec_ready);

  //////////////////////////////////////////////////////////////////////////////
  // Decision for the frame at the FIFO head.
  logic [15:0] credit_q [4];
  wire [1:0] sp = head.src[1:0];
  wire ext = head.src < 3'(switch_port_policy_pkg::INT_PORT);
  wire is_lldp = head.kind == switch_port_policy_pkg::KIND_LLDP;
  wire is_bc = head.kind == switch_port_policy_pkg::KIND_BCAST;
  wire is_mc = head.kind == switch_port_policy_pkg::KIND_MCAST;
  wire limited = ext && ((cfg_q[sp].limit == switch_port_policy_pkg::LIMIT_BCAST && is_bc) ||
                 (cfg_q[sp].limit == switch_port_policy_pkg::LIMIT_MCAST_BCAST &&
                 (is_bc || is_mc)));
  wire over = limited && credit_q[sp] < head.len;
  wire [4:0] self_mask = 5'h01 << head.src;
  wire [4:0] vlan_row = head.src <= 3'(switch_port_policy_pkg::INT_PORT) ? vlan_q[head.src] : 5'h00;
  wire [4:0] base = head.dest & vlan_row;
  wire [4:0] lldp_fwd = ext ? (receives(cfg_q[sp].lldp) ? 5'h10 : 5'h00)
                            : base & {1'b1, send_mask};
  wire [4:0] pass = over ? 5'h00 : (is_lldp ? lldp_fwd : base);
  wire ing_mir = ext && (cfg_q[sp].mirror == switch_port_policy_pkg::MIR_INGRESS ||
                 cfg_q[sp].mirror == switch_port_policy_pkg::MIR_BOTH);
  wire mir_need = !over && (ing_mir || |(pass[3:0] & egmir_mask));
  wire [3:0] mdest = dest_mask & (~dest_mask + 4'h1);
  wire [4:0] egress = (pass | (mir_need ? {1'b0, mdest} : 5'h00)) & ~self_mask;

  // Only the lowest port with the destination role receives mirror copies.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_dec_valid <= 1'b0;
      o_dec <= '0;
    end else if (take) begin
      o_dec_valid <= 1'b1;
      o_dec.src <= head.src;
      o_dec.len <= head.len;
      o_dec.egress <= egress;
      o_dec.dropped <= egress == 5'h00;
    end else if (i_dec_ready) begin
      o_dec_valid <= 1'b0;
    end
  end

  // Credit saturates at the cap; an accepted limited frame spends its length.
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < 4; i++) begin
      logic [16:0] sum;
      sum = {1'b0, credit_q[i]};
      if (refill_tick) begin
        unique case (cfg_q[i].limit)
          switch_port_policy_pkg::LIMIT_BCAST: sum = sum + {1'b0, switch_port_policy_pkg::BCAST_BYTES};
          switch_port_policy_pkg::LIMIT_MCAST_BCAST: sum = sum + {1'b0, switch_port_policy_pkg::MCBC_BYTES};
          default: sum = {1'b0, switch_port_policy_pkg::CREDIT_CAP};
        endcase
      end
      if (take && limited && !over && sp == 2'(i)) begin
        sum = sum - {1'b0, head.len};
      end
      if (i_sys_rst || sum > {1'b0, switch_port_policy_pkg::CREDIT_CAP}) begin
        credit_q[i] <= switch_port_policy_pkg::CREDIT_CAP;
      end else begin
        credit_q[i] <= sum[15:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  logic [4:0] row_seen_q;
  logic [4:0] mir_seen_q;
  always_ff @(posedge i_clk) begin
    if (take) begin
      row_seen_q <= vlan_row;
      mir_seen_q <= {1'b0, mdest};
    end
  end

  chk_no_hairpin: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_dec_valid |-> !o_dec.egress[o_dec.src]) else $error("frame sent back to its source");

  chk_vlan_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    take |=> (o_dec.egress & ~row_seen_q & ~mir_seen_q) == 5'h00)
    else $error("frame sent to a disabled port");

  chk_reset_vlan: assert property (@(posedge i_clk)
    $past(i_sys_rst) && i_sys_rst |-> vlan_q[0] == 5'h1f && vlan_q[4] == 5'h1f)
    else $error("forwarding matrix not fully enabled at reset");

  chk_reset_cfg: assert property (@(posedge i_clk)
    $past(i_sys_rst) |-> cfg_q[0].speed == switch_port_policy_pkg::SPEED_AUTO &&
    cfg_q[3].speed == switch_port_policy_pkg::SPEED_AUTO)
    else $error("port speed not automatic after reset");

  chk_lldp_off_drop: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    take && is_lldp && ext && !receives(cfg_q[sp].lldp) |=> o_dec.dropped)
    else $error("received lldp frame processed while reception is off");

  chk_lldp_rx_proc: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    take && is_lldp && ext && receives(cfg_q[sp].lldp) && !over && head.src != 3'h4
    |=> o_dec.egress[4]) else $error("received lldp frame not processed");

  chk_lldp_tx_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (o_lldp_tx_req & ~$past(send_mask)) == 4'h0) else $error("lldp sent on a non-sending port");

  chk_limit_drop: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    take && over ##1 o_dec_valid |-> o_dec.dropped) else $error("over-budget frame forwarded");

  chk_mirror_ingress: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    take && ing_mir && !over && |mdest && !(|(mdest & self_mask[3:0]))
    |=> |(o_dec.egress[3:0] & mir_seen_q[3:0])) else $error("ingress copy not mirrored");

  chk_advertise: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cfg_q[0].adv_fixed ##1 cfg_q[0].adv_fixed |-> phy_q[0].advertise)
    else $error("fixed port does not advertise");

  chk_reset_phy: assert property (@(posedge i_clk)
    $past(i_sys_rst) |-> phy_q[2].autoneg &&
    phy_q[2].duplex == switch_port_policy_pkg::DUPLEX_AUTO)
    else $error("port duplex not automatic after reset");

  chk_phy_speed: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !$past(i_sys_rst) |-> phy_q[1].speed == $past(cfg_q[1].speed))
    else $error("port speed setting not applied");

  chk_lldp_period: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    lldp_tick |=> o_lldp_tx_req == $past(send_mask)) else $error("lldp announcement missed");

  chk_mirror_egress: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    take && !over && |(pass[3:0] & egmir_mask) && |mdest && !(|(mdest & self_mask[3:0]))
    |=> |(o_dec.egress[3:0] & mir_seen_q[3:0])) else $error("egress copy not mirrored");

  chk_mirror_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    take && !is_lldp && !ing_mir && !(|(pass[3:0] & egmir_mask))
    |=> (o_dec.egress & ~row_seen_q) == 5'h00) else $error("copy made without a mirror role");
endmodule : switch_port_policy

//--- switch_port_policy_sink.sv
/*
  Decision consumer standing at the far side of the switch port policy block.
  Assumes one clock and a synchronous active-high reset shared with the block.
*/
module switch_port_policy_sink (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_hold,
  input wire logic i_slow,
  output logic o_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pat_q;
  // Stalls follow a free-running pattern so back-pressure lands at awkward points.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pat_q <= 8'h5b;
    end else begin
      pat_q <= {pat_q[6:0], pat_q[7] ^ pat_q[5] ^ pat_q[4] ^ pat_q[3]};
    end
  end
  assign o_ready = !i_hold && (!i_slow || pat_q[0]);
endmodule : switch_port_policy_sink

//--- switch_port_policy_tb.sv
/*
  Self-checking bench for the switch port policy block.
  Assumes the package and the design files are compiled first.
*/
module switch_port_policy_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] UNI = switch_port_policy_pkg::KIND_UNICAST;
  localparam logic [1:0] MC = switch_port_policy_pkg::KIND_MCAST;
  localparam logic [1:0] BC = switch_port_policy_pkg::KIND_BCAST;
  localparam logic [1:0] LL = switch_port_policy_pkg::KIND_LLDP;
  localparam logic [5:0] AUTO_PHY = 6'h30;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_cfg_wr = 1'b0;
  logic [1:0] i_cfg_port = 2'h0;
  logic [11:0] i_cfg = 12'h0;
  logic i_vlan_wr = 1'b0;
  logic [2:0] i_vlan_port = 3'h0;
  logic [4:0] i_vlan_row = 5'h1f;
  logic i_in_valid = 1'b0;
  logic [25:0] i_in_desc = 26'h0;
  logic hold = 1'b0;
  logic slow = 1'b0;
  logic rdy;
  logic o_in_ready;
  logic o_dec_valid;
  switch_port_policy_pkg::decision_type o_dec;
  switch_port_policy_pkg::port_cfg_type o_port_cfg [4];
  switch_port_policy_pkg::phy_ctl_type o_phy_ctl [4];
  logic [3:0] o_lldp_tx_req;
  logic [24:0] exp_q [$];
  int n_fail = 0;
  int samples_checked = 0;
  int lldp_cnt [4] = '{0, 0, 0, 0};
  logic [31:0] seed = 32'hee8e;

  always #2.5 i_clk = ~i_clk;

  switch_port_policy #(.REFILL_CYCLES(50), .LLDP_PERIOD_CYCLES(40), .FIFO_DEPTH(16)) uut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cfg_wr(i_cfg_wr), .i_cfg_port(i_cfg_port),
    .i_cfg(i_cfg), .i_vlan_wr(i_vlan_wr), .i_vlan_port(i_vlan_port), .i_vlan_row(i_vlan_row),
    .i_in_valid(i_in_valid), .o_in_ready(o_in_ready), .i_in_desc(i_in_desc),
    .o_dec_valid(o_dec_valid), .i_dec_ready(rdy), .o_dec(o_dec), .o_port_cfg(o_port_cfg),
    .o_phy_ctl(o_phy_ctl), .o_lldp_tx_req(o_lldp_tx_req));
  switch_port_policy_sink sink (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hold(hold),
    .i_slow(slow), .o_ready(rdy));

////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (e !== s) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask : chk

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Speed and duplex stay on auto; limit, LLDP mode and mirror role vary.
  function automatic logic [11:0] cfgv(input logic [1:0] lim, input logic [1:0] ll,
                                       input logic [2:0] mir);
    return {5'h00, lim, ll, mir};
  endfunction : cfgv

  task automatic setcfg(input logic [1:0] p, input logic [11:0] c, input logic [5:0] ph);
    i_cfg_wr <= 1'b1;
    i_cfg_port <= p;
    i_cfg <= c;
    @(posedge i_clk);
    i_cfg_wr <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    chk("port_cfg", 32'(c), 32'(o_port_cfg[p]));
    chk("phy_ctl", 32'(ph), 32'(o_phy_ctl[p]));
    @(posedge i_clk);
  endtask : setcfg

  task automatic setvlan(input logic [2:0] p, input logic [4:0] row);
    i_vlan_wr <= 1'b1;
    i_vlan_port <= p;
    i_vlan_row <= row;
    @(posedge i_clk);
    i_vlan_wr <= 1'b0;
    @(posedge i_clk);
  endtask : setvlan

  // A descriptor is held until the block takes it; its decision is queued for the monitor.
  task automatic send(input logic [2:0] src, input logic [1:0] kind, input logic [15:0] len,
                      input logic [4:0] dest, input logic [4:0] egr);
    i_in_valid <= 1'b1;
    i_in_desc <= {src, kind, len, dest};
    @(negedge i_clk);
    while (o_in_ready !== 1'b1) @(negedge i_clk);
    exp_q.push_back({src, len, egr, egr == 5'h00});
    @(posedge i_clk);
  endtask : send

  task automatic drain();
    i_in_valid <= 1'b0;
    repeat (400) begin
      if (exp_q.size() == 0) break;
      @(posedge i_clk);
    end
    chk("pending", 32'h0, 32'(exp_q.size()));
  endtask : drain

////////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk) begin
    for (int p = 0; p < 4; p++) lldp_cnt[p] += int'(o_lldp_tx_req[p] === 1'b1);
    if (!i_sys_rst && o_dec_valid === 1'b1 && rdy === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("extra_decision", 32'h0, 32'h1);
      end else begin
        chk("decision", 32'(exp_q.pop_front()), 32'(o_dec));
      end
    end
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    complete_run();
  end

  initial begin
    logic [2:0] src;
    int n;
    int base [4];
    logic [2:0] mir;
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_clk);
    chk("reset_ready", 32'h1, 32'(o_in_ready));
    chk("reset_lldp", 32'h0, 32'(o_lldp_tx_req));
    for (int p = 0; p < 4; p++) begin
      chk("reset_cfg", 32'(switch_port_policy_pkg::CFG_RESET), 32'(o_port_cfg[p]));
      chk("reset_phy", 32'(AUTO_PHY), 32'(o_phy_ctl[p]));
    end
    @(posedge i_clk);
    // Random unicast traffic under default settings, with a stalling sink.
    slow <= 1'b1;
    for (int i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      src = 3'(seed[7:0] % 5);
      send(src, UNI, seed[31:16], seed[12:8], seed[12:8] & ~(5'h01 << src));
    end
    drain();
    // Fill until refused: sixteen in the buffer plus one held in the decision stage.
    hold <= 1'b1;
    n = 0;
    i_in_valid <= 1'b1;
    i_in_desc <= {3'h4, UNI, 16'h0040, 5'h01};
    for (int i = 0; i < 20; i++) begin
      @(negedge i_clk);
      if (o_in_ready === 1'b1) begin
        exp_q.push_back({3'h4, 16'h0040, 5'h01, 1'b0});
        n++;
      end
      @(posedge i_clk);
    end
    chk("fifo_taken", 32'd17, 32'(n));
    hold <= 1'b0;
    drain();
    for (int s = 1; s < 4; s++) begin
      setcfg(2'(s - 1), {2'(s), 2'h1, 1'b1, 7'h00}, {2'h1, 2'(s), 2'h1});
    end
    setcfg(2'h3, {2'h0, 2'h2, 8'h00}, {AUTO_PHY[5:2], 2'h2});
    // LLDP modes off, send, receive, both on ports 0 to 3.
    for (int p = 0; p < 4; p++) setcfg(2'(p), cfgv(2'h1, 2'(p), 3'h0), AUTO_PHY);
    for (int p = 0; p < 4; p++) base[p] = lldp_cnt[p];
    for (int p = 0; p < 4; p++) send(3'(p), LL, 16'h0040, 5'h1f, p[1] ? 5'h10 : 5'h00);
    send(3'h4, LL, 16'h0040, 5'h1f, 5'h0a);
    drain();
    repeat (200) @(posedge i_clk);
    for (int p = 0; p < 4; p++) chk("lldp_tx", 32'(p[0]), 32'(lldp_cnt[p] > base[p]));
    // Limiter: port 0 broadcast, port 1 combined, port 2 off.
    slow <= 1'b0;
    for (int p = 0; p < 3; p++) begin
      setcfg(2'(p), cfgv(2'(p == 1 ? 2 : p == 0), 2'h3, 3'h0), AUTO_PHY);
    end
    send(3'h0, BC, 16'd1536, 5'h1f, 5'h1e);
    send(3'h0, BC, 16'd100, 5'h1f, 5'h00);
    send(3'h0, MC, 16'd100, 5'h1f, 5'h1e);
    send(3'h1, MC, 16'd1536, 5'h1f, 5'h1d);
    send(3'h1, BC, 16'd200, 5'h1f, 5'h00);
    for (int i = 0; i < 2; i++) send(3'h2, BC, 16'd1600, 5'h1f, 5'h1b);
    drain();
    setvlan(3'h1, 5'h05);
    setvlan(3'h0, 5'h01);
    setvlan(3'h4, 5'h03);
    send(3'h1, UNI, 16'h0040, 5'h1f, 5'h05);
    send(3'h0, UNI, 16'h0040, 5'h1f, 5'h00);
    send(3'h4, UNI, 16'h0040, 5'h1f, 5'h03);
    drain();
    for (int p = 0; p < 5; p++) setvlan(3'(p), 5'h1f);
    // Mirror roles: ingress, both, egress, destination on ports 0 to 3.
    slow <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      mir = 3'(p == 0 ? 2 : p == 1 ? 3 : p == 2 ? 1 : 4);
      setcfg(2'(p), cfgv(2'h1, 2'h3, mir), AUTO_PHY);
    end
    send(3'h0, UNI, 16'h0040, 5'h02, 5'h0a);
    send(3'h4, UNI, 16'h0040, 5'h04, 5'h0c);
    send(3'h4, UNI, 16'h0040, 5'h01, 5'h01);
    send(3'h1, UNI, 16'h0040, 5'h10, 5'h18);
    drain();
    complete_run();
  end
endmodule : switch_port_policy_tb
